// File: hdl/emhm_map.svh
// register offsets, field positions, reset values and widths of the
// embedded hard multiplier; definitions only, included by bare name
`ifndef EMHM_MAP_SVH
`define EMHM_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define EMHM_CFG_OFS     12'h000
`define EMHM_PLO_OFS     12'h004
`define EMHM_PHI_OFS     12'h008

// ----------------------------------------------------------------------
// configuration field positions
// ----------------------------------------------------------------------
`define EMHM_CFG_MODE    0
`define EMHM_CFG_REG_A   1
`define EMHM_CFG_REG_B   2
`define EMHM_CFG_REG_SA  3
`define EMHM_CFG_REG_SB  4
`define EMHM_CFG_REG_OUT 5
`define EMHM_CFG_SGN_EN  6
`define EMHM_CFG_W       7

// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define EMHM_CFG_RST     7'h01
`define EMHM_OP_W        18
`define EMHM_HALF_W      9
`define EMHM_PROD_W      36
`define EMHM_PHI_W       4

`endif

// File: hdl/emhm_mul_core.sv
// multiplier array: one 18x18 or two 9x9 full precision products
// assumes operands are already selected between registers and bypass
`timescale 1ns/1ps
`default_nettype none

`include "emhm_map.svh"

module emhm_mul_core
(
    emhm_mul_if.core m
);

    // ------------------------------------------------------------------
    // sign extension by one bit, so each operand fits a signed multiply
    // ------------------------------------------------------------------
    function automatic logic signed [`EMHM_OP_W:0] ext_wide
    (
        input logic [`EMHM_OP_W-1:0] v,
        input logic                  s
    );
        return {s & v[`EMHM_OP_W-1], v};
    endfunction

    function automatic logic signed [`EMHM_HALF_W:0] ext_half
    (
        input logic [`EMHM_HALF_W-1:0] v,
        input logic                    s
    );
        return {s & v[`EMHM_HALF_W-1], v};
    endfunction

    logic signed [2*`EMHM_OP_W+1:0]   p_wide;
    logic signed [2*`EMHM_HALF_W+1:0] p_lo;
    logic signed [2*`EMHM_HALF_W+1:0] p_hi;

    // ------------------------------------------------------------------
    // products, no truncation beyond the sum of operand widths
    // ------------------------------------------------------------------
    always_comb
    begin
        p_wide = ext_wide(m.a, m.sa) * ext_wide(m.b, m.sb);
        p_lo   = ext_half(m.a[`EMHM_HALF_W-1:0], m.sa)
               * ext_half(m.b[`EMHM_HALF_W-1:0], m.sb);
        // both halves share one pair of selects
        p_hi   = ext_half(m.a[`EMHM_OP_W-1:`EMHM_HALF_W], m.sa)
               * ext_half(m.b[`EMHM_OP_W-1:`EMHM_HALF_W], m.sb);
    end

    // one product or two concurrent ones, by mode
    always_comb
    begin
        if (m.mode == emhm_pkg::EMHM_MODE_WIDE)
        begin
            m.prod = p_wide[`EMHM_PROD_W-1:0];
        end
        else
        begin
            m.prod = {p_hi[2*`EMHM_HALF_W-1:0], p_lo[2*`EMHM_HALF_W-1:0]};
        end
        m.psgn = m.sa | m.sb;
    end

endmodule

`default_nettype wire

// File: hdl/emhm_mul_if.sv
// carrier between the multiplier top and its array
// assumes one clock domain; the array is purely combinational
`timescale 1ns/1ps
`default_nettype none

`include "emhm_map.svh"

interface emhm_mul_if;
    emhm_pkg::emhm_mode_t       mode;
    logic [`EMHM_OP_W-1:0]      a;
    logic [`EMHM_OP_W-1:0]      b;
    logic                       sa;
    logic                       sb;
    logic [`EMHM_PROD_W-1:0]    prod;
    logic                       psgn;

    // array side computes, top side feeds and consumes
    modport core (input mode, input a, input b, input sa, input sb,
                  output prod, output psgn);
    modport ctrl (output mode, output a, output b, output sa, output sb,
                  input prod, input psgn);
endinterface

`default_nettype wire

// File: hdl/emhm_pkg.sv
// types shared by the multiplier top, its array and the carrier
// assumes emhm_map.svh is visible where the field widths are needed
`default_nettype none

package emhm_pkg;

    // ------------------------------------------------------------------
    // width mode of one instance
    // ------------------------------------------------------------------
    typedef enum logic
    {
        EMHM_MODE_DUAL = 1'b0,
        EMHM_MODE_WIDE = 1'b1
    } emhm_mode_t;

    // ------------------------------------------------------------------
    // configuration word, msb first
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic       sgn_en;
        logic       reg_out;
        logic       reg_sb;
        logic       reg_sa;
        logic       reg_b;
        logic       reg_a;
        emhm_mode_t mode;
    } emhm_cfg_t;

    // register selected by an apb address
    typedef enum logic [1:0]
    {
        EMHM_SEL_CFG  = 2'h0,
        EMHM_SEL_PLO  = 2'h1,
        EMHM_SEL_PHI  = 2'h2,
        EMHM_SEL_NONE = 2'h3
    } emhm_sel_t;

endpackage

`default_nettype wire

// File: hdl/emhm_top.sv
// embedded hard multiplier with optional input and output registers,
// configured over apb; operands come from logic on pclk
// Function
// - instance configures as one 18x18 or two independent 9x9 multipliers
// - computes one or two products concurrently; smaller widths also served
// - each operand registered or bypassed as one 18 bit section, both 9 bit halves together
// - register or bypass chosen independently per operand input
// - all registers share one clock, one enable, one asynchronous clear
// - sign select high means signed operand, low means unsigned
// - product is signed when any operand is signed
// - exactly one sign select for A and one for B
// - sign selects may change at run time, applied to accompanying operands
// - each sign select optionally passes its own input register
// - product is full precision, width is sum of operand widths
// - product optionally registered as one 36 bit word, both halves together
// - with sign selects unused the multiply is unsigned
// - wide mode serves 10 to 18 bits, dual mode up to 9 bits
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none

`include "emhm_map.svh"

module emhm_top
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic [11:0]               paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      mult_ena,
    input  wire logic                      mult_clr,
    input  wire logic [`EMHM_OP_W-1:0]     op_a,
    input  wire logic [`EMHM_OP_W-1:0]     op_b,
    input  wire logic                      sign_a,
    input  wire logic                      sign_b,
    output logic      [`EMHM_PROD_W-1:0]   product,
    output logic                           product_signed
);

    // ------------------------------------------------------------------
    // apb address decode, used by both read and write paths
    // ------------------------------------------------------------------
    function automatic emhm_pkg::emhm_sel_t reg_sel(input logic [11:0] adr);
        case (adr)
            `EMHM_CFG_OFS: return emhm_pkg::EMHM_SEL_CFG;
            `EMHM_PLO_OFS: return emhm_pkg::EMHM_SEL_PLO;
            `EMHM_PHI_OFS: return emhm_pkg::EMHM_SEL_PHI;
            default:       return emhm_pkg::EMHM_SEL_NONE;
        endcase
    endfunction

    emhm_pkg::emhm_cfg_t         cfg_q;
    emhm_pkg::emhm_sel_t         sel;
    logic                        acc;
    logic                        done;
    logic [31:0]                 rdata_d;
    logic                        pready_q;
    logic                        pslverr_q;
    logic [31:0]                 prdata_q;
    logic [`EMHM_OP_W-1:0]       a_q;
    logic [`EMHM_OP_W-1:0]       b_q;
    logic                        sa_q;
    logic                        sb_q;
    logic                        sa_in;
    logic                        sb_in;
    logic [`EMHM_PROD_W-1:0]     prod_q;
    logic                        psgn_q;

    emhm_mul_if mul ();

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    // access phase with ready already up is the completing edge
    always_comb
    begin
        sel  = reg_sel(paddr);
        acc  = psel & penable;
        done = acc & pready_q;
    end

    // one wait state: ready rises in the second access cycle only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
        end
        else
        begin
            pready_q <= acc & ~pready_q;
        end
    end

    // read mux; the product seen is what the fabric sees
    always_comb
    begin
        case (sel)
            emhm_pkg::EMHM_SEL_CFG:
                rdata_d = {{(32-`EMHM_CFG_W){1'b0}}, cfg_q};
            emhm_pkg::EMHM_SEL_PLO:
                rdata_d = product[31:0];
            emhm_pkg::EMHM_SEL_PHI:
                rdata_d = {{(32-`EMHM_PHI_W){1'b0}},
                           product[`EMHM_PROD_W-1:32]};
            default:
                rdata_d = 32'h0000_0000;
        endcase
    end

    // read data and error are loaded together with ready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if (acc & ~pready_q)
        begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
            pslverr_q <= (sel == emhm_pkg::EMHM_SEL_NONE);
        end
        else
        begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
    end

    // configuration, set while the design is set up; product regs are
    // read only, writes to them are dropped without error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= `EMHM_CFG_RST;
        end
        else if (done && pwrite && pstrb[0] && sel == emhm_pkg::EMHM_SEL_CFG)
        begin
            cfg_q <= pwdata[`EMHM_CFG_W-1:0];
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------------
    // input stage
    // ------------------------------------------------------------------
    // unused sign selects fall back to an unsigned multiply
    always_comb
    begin
        sa_in = sign_a & cfg_q.sgn_en;
        sb_in = sign_b & cfg_q.sgn_en;
    end

    // operand and sign registers; clear is asynchronous and wins over
    // the enable, a low enable holds, one clock for all of them
    always_ff @(posedge pclk or negedge presetn or posedge mult_clr)
    begin
        if (!presetn)
        begin
            a_q  <= '0;
            b_q  <= '0;
            sa_q <= 1'b0;
            sb_q <= 1'b0;
        end
        else if (mult_clr)
        begin
            a_q  <= '0;
            b_q  <= '0;
            sa_q <= 1'b0;
            sb_q <= 1'b0;
        end
        else if (mult_ena)
        begin
            a_q  <= op_a;
            b_q  <= op_b;
            sa_q <= sa_in;
            sb_q <= sb_in;
        end
    end

    // per input register or bypass; 18 bit paths carry both 9 bit halves
    always_comb
    begin
        mul.mode = cfg_q.mode;
        mul.a    = cfg_q.reg_a  ? a_q  : op_a;
        mul.b    = cfg_q.reg_b  ? b_q  : op_b;
        mul.sa   = cfg_q.reg_sa ? sa_q : sa_in;
        mul.sb   = cfg_q.reg_sb ? sb_q : sb_in;
    end

    emhm_mul_core u_core
    (
        .m (mul.core)
    );

    // ------------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------------
    // registered whole; in dual mode the two halves are independent
    // products that just share these flops
    always_ff @(posedge pclk or negedge presetn or posedge mult_clr)
    begin
        if (!presetn)
        begin
            prod_q <= '0;
            psgn_q <= 1'b0;
        end
        else if (mult_clr)
        begin
            prod_q <= '0;
            psgn_q <= 1'b0;
        end
        else if (mult_ena)
        begin
            prod_q <= mul.prod;
            psgn_q <= mul.psgn;
        end
    end

    // bypass leaves the product combinational from the selected operands, port or input register
    assign product        = cfg_q.reg_out ? prod_q : mul.prod;
    assign product_signed = cfg_q.reg_out ? psgn_q : mul.psgn;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    logic [`EMHM_PROD_W-1:0] ref_uns;
    logic [2*`EMHM_HALF_W-1:0] ref_hi;

    // independent references for the unsigned wide path and the upper dual product
    always_comb
    begin
        ref_uns = {{`EMHM_OP_W{1'b0}}, op_a} * {{`EMHM_OP_W{1'b0}}, op_b};
        ref_hi  = 18'($signed({sign_a & op_a[17], op_a[17:9]})
                    * $signed({sign_b & op_b[17], op_b[17:9]}));
    end

    property p_uns_wide;
        @(posedge pclk) disable iff (!presetn)
        (cfg_q == 7'h01) |-> (product == ref_uns) && !product_signed;
    endproperty
    a_uns_wide: assert property (p_uns_wide)
        else $error("unsigned wide product wrong");

    property p_dual_hi;
        @(posedge pclk) disable iff (!presetn)
        (cfg_q == 7'h40) |-> (product[35:18] == ref_hi);
    endproperty
    a_dual_hi: assert property (p_dual_hi)
        else $error("upper dual product wrong");

    property p_sgn_res;
        @(posedge pclk) disable iff (!presetn)
        (cfg_q == 7'h41) |-> (product_signed == (sign_a | sign_b));
    endproperty
    a_sgn_res: assert property (p_sgn_res)
        else $error("product signedness wrong");

    property p_reg_a_only;
        @(posedge pclk) disable iff (!presetn || mult_clr)
        (cfg_q.reg_a && !cfg_q.reg_b && mult_ena && !mult_clr) ##1 $stable(cfg_q)
        |-> (mul.a == $past(op_a)) && (mul.b == op_b);
    endproperty
    a_reg_a_only: assert property (p_reg_a_only)
        else $error("operand A not registered alone");

    property p_sign_reg;
        @(posedge pclk) disable iff (!presetn || mult_clr)
        (cfg_q.reg_sa && cfg_q.sgn_en && mult_ena && !mult_clr) ##1 $stable(cfg_q)
        |-> (mul.sa == $past(sign_a));
    endproperty
    a_sign_reg: assert property (p_sign_reg)
        else $error("sign select register did not load");

    property p_out_reg;
        @(posedge pclk) disable iff (!presetn || mult_clr)
        (cfg_q.reg_out && mult_ena && !mult_clr) ##1 $stable(cfg_q)
        |-> (product == $past(mul.prod));
    endproperty
    a_out_reg: assert property (p_out_reg)
        else $error("output register did not take product");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (!mult_ena && !mult_clr) ##1 !mult_clr
        |-> $stable(prod_q) && $stable(a_q) && $stable(sb_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed with enable low");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        mult_clr |-> (prod_q == '0) && (a_q == '0) && !psgn_q;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero registers");

    property p_cfg_write;
        @(posedge pclk) disable iff (!presetn)
        (done && pwrite && pstrb[0] && paddr == `EMHM_CFG_OFS)
        |=> (cfg_q == $past(pwdata[6:0]));
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("configuration write lost");

    property p_ready_once;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready;
    endproperty
    a_ready_once: assert property (p_ready_once)
        else $error("ready not a single pulse after one wait");

    c_wide_signed: cover property (@(posedge pclk) disable iff (!presetn)
        cfg_q.mode == emhm_pkg::EMHM_MODE_WIDE && product_signed);
    c_dual_reg: cover property (@(posedge pclk) disable iff (!presetn)
        cfg_q.mode == emhm_pkg::EMHM_MODE_DUAL && cfg_q.reg_out && mult_ena);
    c_clear: cover property (@(posedge pclk) disable iff (!presetn)
        mult_clr ##1 !mult_clr);
    c_err: cover property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr);

endmodule

`default_nettype wire

// File: tb/emhm_fabric.sv
// fabric model feeding operands, signs, enable and clear to the multiplier
// assumes one clock; values change just after the rising edge of pclk
`timescale 1ns/1ps
`default_nettype none

module emhm_fabric
(
    input  wire logic        pclk,
    input  wire logic        run,
    output logic      [17:0] op_a,
    output logic      [17:0] op_b,
    output logic             sign_a,
    output logic             sign_b,
    output logic             mult_ena,
    output logic             mult_clr
);
    // ------------------------------------------------------------------
    // operand source
    // ------------------------------------------------------------------
    // narrow values are extended into the field, as the feeder must do
    function automatic logic [17:0] pick();
        logic [17:0] v;
        logic [3:0]  n;
        v = 18'($urandom);
        n = 4'(1 + $urandom % 8);
        case ($urandom % 6)
            0: v = 18'h20000;
            1: v = 18'h3FFFF;
            2: v = {2{9'($signed(9'(v << (9 - n))) >>> (9 - n))}};
            default: ;
        endcase
        return v;
    endfunction

    initial
    begin
        {op_a, op_b, sign_a, sign_b, mult_ena, mult_clr} = '0;
    end

    // one select per operand covers both halves, so signedness stays paired
    always @(posedge pclk)
    begin
        if (run)
        begin
            op_a     <= pick();
            op_b     <= pick();
            sign_a   <= 1'($urandom);
            sign_b   <= 1'($urandom);
            mult_ena <= ($urandom % 8) != 0;
            mult_clr <= ($urandom % 32) == 0;
        end
        else
        begin
            // idle: operands hold, pipeline flushes to a steady product
            mult_ena <= 1'b1;
            mult_clr <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// File: tb/emhm_top_bench.sv
// self-checking bench: apb master, reference model, random fabric feeder
// assumes the design answers apb within a few cycles and resets async
`timescale 1ns/1ps
`default_nettype none

`include "emhm_map.svh"

module emhm_top_bench;
    logic                pclk = 1'b0;
    logic                presetn = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic                run = 1'b0;
    logic                live = 1'b0;
    logic [11:0]         paddr = 12'h000;
    logic [31:0]         pwdata = 32'h0;
    logic [3:0]          pstrb = 4'hF;
    logic [31:0]         prdata;
    logic [31:0]         rd;
    logic                pready;
    logic                pslverr;
    logic                err;
    logic                mult_ena;
    logic                mult_clr;
    logic                sign_a;
    logic                sign_b;
    logic                product_signed;
    logic [17:0]         op_a;
    logic [17:0]         op_b;
    logic [35:0]         product;
    logic [35:0]         pc;
    logic [35:0]         mp;
    logic [17:0]         ma;
    logic [17:0]         mb;
    logic                msa;
    logic                msb;
    logic                mps;
    logic                sae;
    logic                sbe;
    logic [6:0]          cfgv;
    emhm_pkg::emhm_cfg_t cfg_m;
    integer              miscompares = 0;
    integer              checks_done = 0;
    logic [6:0]          corner [7] = '{7'h01, 7'h00, 7'h7F, 7'h43, 7'h4A, 7'h40, 7'h41};

    always #4 pclk = ~pclk;

    emhm_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mult_ena(mult_ena),
        .mult_clr(mult_clr), .op_a(op_a), .op_b(op_b), .sign_a(sign_a),
        .sign_b(sign_b), .product(product), .product_signed(product_signed));

    emhm_fabric u_fab (.pclk(pclk), .run(run), .op_a(op_a), .op_b(op_b),
        .sign_a(sign_a), .sign_b(sign_b), .mult_ena(mult_ena), .mult_clr(mult_clr));

    // ------------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------------
    // full precision: operands extended by one bit, product cut only to the sum of operand widths
    function automatic logic [35:0] mul_exp(logic wide, logic [17:0] a,
                                            logic [17:0] b, logic sa, logic sb);
        logic signed [18:0] xa;
        logic signed [18:0] xb;
        logic signed [37:0] p;
        logic signed [9:0]  la;
        logic signed [9:0]  lb;
        logic signed [9:0]  ha;
        logic signed [9:0]  hb;
        logic signed [19:0] pl;
        logic signed [19:0] ph;
        xa = {sa & a[17], a};
        xb = {sb & b[17], b};
        p  = xa * xb;
        la = {sa & a[8], a[8:0]};
        lb = {sb & b[8], b[8:0]};
        ha = {sa & a[17], a[17:9]};
        hb = {sb & b[17], b[17:9]};
        pl = la * lb;
        ph = ha * hb;
        return wide ? p[35:0] : {ph[17:0], pl[17:0]};
    endfunction

    // sign selects gated by sgn_en after their optional register
    always_comb
    begin
        sae = cfg_m.sgn_en & (cfg_m.reg_sa ? msa : sign_a);
        sbe = cfg_m.sgn_en & (cfg_m.reg_sb ? msb : sign_b);
        pc  = mul_exp(cfg_m.mode, cfg_m.reg_a ? ma : op_a, cfg_m.reg_b ? mb : op_b,
                      sae, sbe);
    end

    // shared enable and asynchronous clear over every register
    always @(posedge pclk or posedge mult_clr or negedge presetn)
    begin
        if (!presetn || mult_clr)
        begin
            {ma, mb, msa, msb, mp, mps} <= '0;
        end
        else if (mult_ena)
        begin
            {ma, mb, msa, msb} <= {op_a, op_b, sign_a, sign_b};
            mp  <= pc;
            mps <= sae | sbe;
        end
    end

    // ------------------------------------------------------------------
    // comparison and apb master
    // ------------------------------------------------------------------
    task automatic check(logic [35:0] seen, logic [35:0] want);
        checks_done++;
        if (seen !== want)
        begin
            miscompares++;
            $display("Error %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic close_out();
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // outputs compared mid-cycle, where they are settled
    always @(negedge pclk)
    begin
        if (live)
        begin
            check(product, cfg_m.reg_out ? mp : pc);
            check(36'(product_signed), 36'(cfg_m.reg_out ? mps : (sae | sbe)));
        end
    end

    task automatic apb(logic wr, logic [11:0] ad, logic [31:0] wd, logic [3:0] st);
        int n;
        // let an edge pass so a release never meets the next setup
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= wd;
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            miscompares++;
            close_out();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    initial
    begin
        void'($urandom(32'h1744d9e1));
        cfg_m = emhm_pkg::emhm_cfg_t'(7'h01);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `EMHM_CFG_OFS, 32'h0, 4'hF);
        check(36'(rd), 36'h01);
        apb(1'b0, 12'h00C, 32'h0, 4'hF);
        check(36'({err, rd}), 36'h100000000);
        apb(1'b1, `EMHM_CFG_OFS, 32'h7E, 4'hE);
        apb(1'b1, `EMHM_PLO_OFS, 32'h7E, 4'hF);
        check(36'(err), 36'h0);
        apb(1'b0, `EMHM_CFG_OFS, 32'h0, 4'hF);
        check(36'(rd), 36'h01);
        for (int t = 0; t < 28; t++)
        begin
            cfgv = (t < 7) ? corner[t] : 7'($urandom);
            apb(1'b1, `EMHM_CFG_OFS, 32'(cfgv), 4'hF);
            cfg_m <= emhm_pkg::emhm_cfg_t'(cfgv);
            apb(1'b0, `EMHM_CFG_OFS, 32'h0, 4'hF);
            check(36'(rd), 36'(cfgv));
            repeat (3) @(posedge pclk);
            live <= 1'b1;
            run  <= 1'b1;
            repeat (60) @(posedge pclk);
            run <= 1'b0;
            repeat (4) @(posedge pclk);
            apb(1'b0, `EMHM_PLO_OFS, 32'h0, 4'hF);
            check(36'(rd), 36'((cfg_m.reg_out ? mp : pc) & 36'hFFFFFFFF));
            apb(1'b0, `EMHM_PHI_OFS, 32'h0, 4'hF);
            check(36'(rd), 36'((cfg_m.reg_out ? mp : pc) >> 32));
            live <= 1'b0;
        end
        close_out();
    end
endmodule

`default_nettype wire
